/* src/dpc_apb_port.sv */
/*
 APB address decode and handshake for the power control bank.
 Assumes an APB master; every access completes with no wait state.
*/
`timescale 1ns/1ps
module dpc_apb_port (
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [dpc_pkg::ADDR_W-1:0] paddr,
   output logic                           hit_ref,
   output logic                           hit_drv,
   output logic                           hit_stat,
   output logic                           wr_commit,
   output logic                           rd_setup,
   output logic                           pready,
   output logic                           pslverr
);
   logic any_hit;

   // Word decode of the three mapped registers
   assign hit_ref  = (paddr == dpc_pkg::dpc_byte_addr(dpc_pkg::IDX_REF));
   assign hit_drv  = (paddr == dpc_pkg::dpc_byte_addr(dpc_pkg::IDX_DRV));
   assign hit_stat = (paddr == dpc_pkg::dpc_byte_addr(dpc_pkg::IDX_STAT));
   assign any_hit  = hit_ref | hit_drv | hit_stat;

   // Writes land at the access edge; reads are fetched in setup
   assign pready    = 1'b1;
   assign wr_commit = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable & ~pwrite;
   assign pslverr   = psel & penable & ~any_hit; // Unmapped word

endmodule : dpc_apb_port

/* src/dpc_pkg.sv */
/*
 Constants and types for the display power control register bank.
 Assumes an APB master with 32-bit data and word-aligned registers.
*/
// Overview of operation
// - Short bit set bridges doubler input to output
// - Doubler running blocks the input-output short
// - Bit 8 of reference register runs doubler
// - Reference contrast in bits 7:4, resets 0x7
// - Bit 2 sets reference heavy-load protection
// - Bit 1 picks higher reference level
// - Bit 0 enables the reference regulator
// - Drive contrast in bits 15:12, resets 0x5
// - Drive range bits 11:10 pick 15/12/9 V
// - Bit 9 sets drive heavy-load protection
// - Bit 8 enables the drive regulator
// - Bit 1 pulls booster output to ground
// - Bit 0 enables the booster
package dpc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_REF  = 16'h5600;
   localparam logic [15:0] IDX_DRV  = 16'h5602;
   localparam logic [15:0] IDX_STAT = 16'h5604;
   localparam int          ADDR_W   = 20;

   // Reference power register fields
   localparam int REF_ON_BIT    = 0;
   localparam int REF_SEL_BIT   = 1;
   localparam int REF_HVY_BIT   = 2;
   localparam int REF_CON_LSB   = 4;
   localparam int DBL_ON_BIT    = 8;
   localparam int DBL_SHORT_BIT = 9;
   localparam logic [15:0] REF_MASK = 16'h03f7;

   // Drive power register fields
   localparam int BST_ON_BIT  = 0;
   localparam int BST_PD_BIT  = 1;
   localparam int DRV_ON_BIT  = 8;
   localparam int DRV_HVY_BIT = 9;
   localparam int DRV_RNG_LSB = 10;
   localparam int DRV_CON_LSB = 12;
   localparam logic [15:0] DRV_MASK = 16'hff03;

   // Status register fields
   localparam int ST_BST_OK_BIT = 0;
   localparam int ST_DRV_OK_BIT = 1;
   localparam int ST_SHORT_BIT  = 2;

   // Reset values
   localparam logic [3:0] REF_CON_RST = 4'h7;
   localparam logic [3:0] DRV_CON_RST = 4'h5;

   // Settling times
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned BST_SETTLE_MS  = 35;
   localparam int unsigned DRV_SETTLE_MS  = 5;
   localparam int unsigned BST_SETTLE_CYC = BST_SETTLE_MS * 1000 * CLK_MHZ;
   localparam int unsigned DRV_SETTLE_CYC = DRV_SETTLE_MS * 1000 * CLK_MHZ;

   typedef enum logic [1:0] {
      DPC_RANGE_15V  = 2'h0,
      DPC_RANGE_12V  = 2'h1,
      DPC_RANGE_9V   = 2'h2,
      DPC_RANGE_RSVD = 2'h3
   } dpc_range_t;

   typedef enum logic [2:0] {
      DPC_ST_IDLE  = 3'b001,
      DPC_ST_COUNT = 3'b010,
      DPC_ST_DONE  = 3'b100
   } dpc_settle_st_t;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] dpc_byte_addr(input logic [15:0] idx);
      dpc_byte_addr = {2'b00, idx, 2'b00};
   endfunction : dpc_byte_addr

   // Apply byte strobes to a 16-bit register, keeping reserved bits zero
   function automatic logic [15:0] dpc_merge(input logic [15:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb,
                                             input logic [15:0] mask);
      logic [15:0] v;
      v = old_val;
      if (strb[0]) begin
         v[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         v[15:8] = wdata[15:8];
      end
      dpc_merge = v & mask;
   endfunction : dpc_merge

endpackage : dpc_pkg

/* src/dpc_regs.sv */
/*
 Display power chain control register bank, APB slave.
 Holds the reference and drive power registers plus a status word,
 and drives the level controls of the regulators, doubler and booster.
 Assumes pclk at 200 MHz, presetn asynchronous active low, and analog
 circuits that sample the control outputs as plain levels.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module dpc_regs #(
   parameter int unsigned BST_SETTLE_CYCLES = dpc_pkg::BST_SETTLE_CYC,
   parameter int unsigned DRV_SETTLE_CYCLES = dpc_pkg::DRV_SETTLE_CYC
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,

   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [dpc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,

   // Reference regulator and doubler controls
   output logic                            reference_regulator_enable,
   output logic                            reference_level_select,
   output logic                            reference_heavy_load_mode,
   output logic      [3:0]                 reference_contrast_level,
   output logic                            doubler_enable,
   output logic                            doubler_bypass_short,

   // Booster and drive regulator controls
   output logic                            booster_enable,
   output logic                            booster_pulldown,
   output logic                            drive_regulator_enable,
   output logic                            drive_heavy_load_mode,
   output logic      [1:0]                 drive_range_select,
   output logic      [3:0]                 drive_contrast_level,

   // Settling status
   output logic                            boosted_voltage_settled,
   output logic                            display_drive_voltage_settled
);

   // Timers shorter than two cycles cannot express a settling wait
   if (BST_SETTLE_CYCLES < 2 || DRV_SETTLE_CYCLES < 2) begin : g_bad_settle
      $error("dpc_regs: settle cycle counts must be at least 2");
   end

   // Register state of the bank apart from the two settle timers
   typedef struct packed {
      logic [15:0] ref_reg;
      logic [15:0] drv_reg;
      logic        short_applied;
      logic [31:0] rdata;
   } dpc_state_t;

   dpc_state_t state;
   dpc_state_t next_state;

   // Decode results
   logic hit_ref;
   logic hit_drv;
   logic hit_stat;
   logic wr_commit;
   logic rd_setup;

   // Settling flags
   logic bst_settled;
   logic drv_settled;

   // Status word assembled from the block's own state
   logic [15:0] stat_word;

   // Bus decode and handshake
   dpc_apb_port u_port (
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .hit_ref   (hit_ref),
      .hit_drv   (hit_drv),
      .hit_stat  (hit_stat),
      .wr_commit (wr_commit),
      .rd_setup  (rd_setup),
      .pready    (pready),
      .pslverr   (pslverr)
   );

   // Boosted voltage settles after the booster has run long enough.
   // The flag only informs software; the drive regulator is not held
   // off by hardware, so an early enable is the software's risk.
   dpc_settle_timer #(
      .CYCLES (BST_SETTLE_CYCLES)
   ) u_bst_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (state.drv_reg[dpc_pkg::BST_ON_BIT]),
      .settled (bst_settled)
   );

   // Drive voltage settles after the drive regulator has run long enough
   dpc_settle_timer #(
      .CYCLES (DRV_SETTLE_CYCLES)
   ) u_drv_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (state.drv_reg[dpc_pkg::DRV_ON_BIT]),
      .settled (drv_settled)
   );

   // Status word; bits above the three flags read as zero
   always_comb begin
      stat_word = 16'h0000;
      stat_word[dpc_pkg::ST_BST_OK_BIT] = bst_settled;
      stat_word[dpc_pkg::ST_DRV_OK_BIT] = drv_settled;
      stat_word[dpc_pkg::ST_SHORT_BIT]  = state.short_applied;
   end

   // Next state: writes, gated short and read fetch
   always_comb begin
      next_state = state;

      // Writes merge through byte strobes, reserved bits forced low
      if (wr_commit && hit_ref) begin
         next_state.ref_reg = dpc_pkg::dpc_merge(state.ref_reg, pwdata, pstrb,
                                                 dpc_pkg::REF_MASK);
      end
      if (wr_commit && hit_drv) begin
         next_state.drv_reg = dpc_pkg::dpc_merge(state.drv_reg, pwdata, pstrb,
                                                 dpc_pkg::DRV_MASK);
      end

      // Short only while the doubler is stopped, else its output is lost.
      // Taken from the next values so it moves on the same edge as the bits.
      next_state.short_applied =
         next_state.ref_reg[dpc_pkg::DBL_SHORT_BIT] &
         ~next_state.ref_reg[dpc_pkg::DBL_ON_BIT];

      // Read data is fetched in setup so it comes from a flop in access
      if (rd_setup) begin
         next_state.rdata = 32'h0000_0000;
         if (hit_ref) begin
            next_state.rdata = {16'h0000, state.ref_reg};
         end else if (hit_drv) begin
            next_state.rdata = {16'h0000, state.drv_reg};
         end else if (hit_stat) begin
            next_state.rdata = {16'h0000, stat_word};
         end
      end
   end

   // State register; every field takes its documented default
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '{
            ref_reg:       {6'h00, 2'b00, dpc_pkg::REF_CON_RST, 4'h0},
            drv_reg:       {dpc_pkg::DRV_CON_RST, 12'h000},
            short_applied: 1'b0,
            rdata:         32'h0000_0000
         };
      end else begin
         state <= next_state;
      end
   end

   // Bus read data
   assign prdata = state.rdata;

   // Reference regulator controls
   assign reference_regulator_enable = state.ref_reg[dpc_pkg::REF_ON_BIT];
   assign reference_level_select     = state.ref_reg[dpc_pkg::REF_SEL_BIT];
   assign reference_heavy_load_mode  = state.ref_reg[dpc_pkg::REF_HVY_BIT];
   assign reference_contrast_level   =
      state.ref_reg[dpc_pkg::REF_CON_LSB +: 4];

   // Doubler controls; the raw short bit is never driven out directly
   assign doubler_enable       = state.ref_reg[dpc_pkg::DBL_ON_BIT];
   assign doubler_bypass_short = state.short_applied;

   // Booster controls; pull-down is passed as written, even with booster on
   assign booster_enable   = state.drv_reg[dpc_pkg::BST_ON_BIT];
   assign booster_pulldown = state.drv_reg[dpc_pkg::BST_PD_BIT];

   // Drive regulator controls; reserved range code is passed unchanged
   assign drive_regulator_enable = state.drv_reg[dpc_pkg::DRV_ON_BIT];
   assign drive_heavy_load_mode  = state.drv_reg[dpc_pkg::DRV_HVY_BIT];
   assign drive_range_select     = state.drv_reg[dpc_pkg::DRV_RNG_LSB +: 2];
   assign drive_contrast_level   = state.drv_reg[dpc_pkg::DRV_CON_LSB +: 4];

   // Settling status
   assign boosted_voltage_settled       = bst_settled;
   assign display_drive_voltage_settled = drv_settled;

endmodule : dpc_regs

/* src/dpc_settle_timer.sv */
/*
 Settling timer: counts from enable rise, flags settled when done.
 Assumes enable is a registered level in the pclk domain.
*/
`timescale 1ns/1ps
module dpc_settle_timer #(
   parameter int unsigned CYCLES = 1000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   output logic      settled
);
   localparam int CW = $clog2(CYCLES + 1);

   if (CYCLES < 2) begin : g_bad_cycles
      $error("dpc_settle_timer: CYCLES must be at least 2");
   end

   typedef struct packed {
      dpc_pkg::dpc_settle_st_t st;
      logic [CW-1:0]           cnt;
   } dpc_tmr_t;

   dpc_tmr_t state;
   dpc_tmr_t next_state;

   // Disabling restarts the wait, so a brief drop cannot look settled
   always_comb begin
      next_state = state;
      unique case (state.st)
         dpc_pkg::DPC_ST_IDLE: begin
            next_state.cnt = '0;
            if (enable) begin
               next_state.st  = dpc_pkg::DPC_ST_COUNT;
               next_state.cnt = CW'(1);
            end
         end
         dpc_pkg::DPC_ST_COUNT: begin
            if (!enable) begin
               next_state.st = dpc_pkg::DPC_ST_IDLE;
            end else if (state.cnt == CW'(CYCLES)) begin
               next_state.st = dpc_pkg::DPC_ST_DONE;
            end else begin
               next_state.cnt = state.cnt + CW'(1);
            end
         end
         dpc_pkg::DPC_ST_DONE: begin
            if (!enable) begin
               next_state.st = dpc_pkg::DPC_ST_IDLE;
            end
         end
         default: begin
            next_state.st = dpc_pkg::DPC_ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '{st: dpc_pkg::DPC_ST_IDLE, cnt: '0};
      end else begin
         state <= next_state;
      end
   end

   assign settled = (state.st == dpc_pkg::DPC_ST_DONE);

endmodule : dpc_settle_timer

/* tb/dpc_analog_model.sv */
/*
 Behavioural stand-in for the doubler, booster and drive regulator.
 Assumes the control inputs are plain levels; no voltages are modelled.
*/
`timescale 1ns/1ps
module dpc_analog_model (
   input wire logic doubler_enable,
   input wire logic doubler_bypass_short,
   input wire logic booster_enable,
   input wire logic booster_pulldown,
   input wire logic drive_regulator_enable,
   output logic     short_live,
   output logic     hv_live
);
   // Bridge closes only when the short is asked for and the doubler is idle
   assign short_live = doubler_bypass_short & ~doubler_enable;
   // Drive voltage needs booster and regulator; pull-down always wins
   assign hv_live = booster_enable & drive_regulator_enable & ~booster_pulldown;
endmodule : dpc_analog_model

/* tb/dpc_regs_monitor.sv */
/*
 Concurrent checks on the power control bank ports.
 Assumes single-cycle APB access and registered control outputs.
*/
`timescale 1ns/1ps
module dpc_regs_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        reference_regulator_enable,
   input wire logic        reference_level_select,
   input wire logic        reference_heavy_load_mode,
   input wire logic [3:0]  reference_contrast_level,
   input wire logic        doubler_enable,
   input wire logic        doubler_bypass_short,
   input wire logic        booster_enable,
   input wire logic        booster_pulldown,
   input wire logic        drive_regulator_enable,
   input wire logic        drive_heavy_load_mode,
   input wire logic [1:0]  drive_range_select,
   input wire logic [3:0]  drive_contrast_level
);
   localparam logic [19:0] A_REF = 20'h15800;
   localparam logic [19:0] A_DRV = 20'h15808;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Decoded access phases; kept here so each property stays short
   wire logic        acc    = psel & penable;
   wire logic        wr_ref = acc & pwrite & (paddr == A_REF);
   wire logic        wr_drv = acc & pwrite & (paddr == A_DRV);
   wire logic [18:0] ctl    = {reference_regulator_enable, reference_level_select,
      reference_heavy_load_mode, reference_contrast_level, doubler_enable, doubler_bypass_short,
      booster_enable, booster_pulldown, drive_regulator_enable, drive_heavy_load_mode,
      drive_range_select, drive_contrast_level};
   // Control fields follow the written word one edge later
   a_short_gate: assert property (doubler_enable |-> !doubler_bypass_short)
      else $error("short applied while doubler runs");
   a_ref_low_wr: assert property (wr_ref && pstrb[0] |=> {reference_contrast_level,
      reference_heavy_load_mode, reference_level_select, reference_regulator_enable}
      == {$past(pwdata[7:4]), $past(pwdata[2:0])}) else $error("reference low byte mismatch");
   a_ref_high_wr: assert property (wr_ref && pstrb[1] |=> doubler_enable == $past(pwdata[8])
      && doubler_bypass_short == ($past(pwdata[9]) && !$past(pwdata[8])))
      else $error("doubler controls mismatch");
   a_drv_high_wr: assert property (wr_drv && pstrb[1] |=> {drive_contrast_level,
      drive_range_select, drive_heavy_load_mode, drive_regulator_enable} == $past(pwdata[15:8]))
      else $error("drive high byte mismatch");
   a_drv_low_wr: assert property (wr_drv && pstrb[0] |=>
      {booster_pulldown, booster_enable} == $past(pwdata[1:0])) else $error("booster mismatch");
   a_ctrl_hold: assert property (!(acc && pwrite) |=> $stable(ctl))
      else $error("controls moved without a write");
   // Read data mirrors the controls; reserved positions stay zero
   a_ref_read: assert property (acc && !pwrite && paddr == A_REF |-> prdata[31:10] == 22'h0
      && prdata[8:0] == {doubler_enable, reference_contrast_level, 1'b0, reference_heavy_load_mode,
      reference_level_select, reference_regulator_enable}) else $error("reference read mismatch");
   a_drv_read: assert property (acc && !pwrite && paddr == A_DRV |-> prdata == {16'h0,
      drive_contrast_level, drive_range_select, drive_heavy_load_mode, drive_regulator_enable,
      6'h0, booster_pulldown, booster_enable}) else $error("drive read mismatch");
   c_short_req: cover property (wr_ref && pwdata[9] && !pwdata[8]);
   c_bad_addr: cover property (acc && pslverr);
   c_drv_read: cover property (acc && !pwrite && paddr == A_DRV);
endmodule : dpc_regs_monitor

bind dpc_regs dpc_regs_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pslverr(pslverr), .reference_regulator_enable(reference_regulator_enable),
   .reference_level_select(reference_level_select),
   .reference_heavy_load_mode(reference_heavy_load_mode),
   .reference_contrast_level(reference_contrast_level), .doubler_enable(doubler_enable),
   .doubler_bypass_short(doubler_bypass_short), .booster_enable(booster_enable),
   .booster_pulldown(booster_pulldown), .drive_regulator_enable(drive_regulator_enable),
   .drive_heavy_load_mode(drive_heavy_load_mode), .drive_range_select(drive_range_select),
   .drive_contrast_level(drive_contrast_level));

/* tb/testbench.sv */
/*
 Self-checking bench for the power control bank over APB.
 Assumes short settle counts so the power-up sequence fits the run.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module testbench;
   localparam logic [19:0] A_REF = 20'h15800;
   localparam logic [19:0] A_DRV = 20'h15808;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, ref_con, drv_con;
   logic [1:0]  drv_rng;
   logic        ref_en, ref_sel, ref_hvy, dbl_en, dbl_short, bst_en, bst_pd, drv_en, drv_hvy;
   logic        bst_ok, drv_ok, short_live, hv_live;
   int          failures, tests_run;

   dpc_regs #(.BST_SETTLE_CYCLES(20), .DRV_SETTLE_CYCLES(10)) u_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reference_regulator_enable(ref_en), .reference_level_select(ref_sel),
      .reference_heavy_load_mode(ref_hvy), .reference_contrast_level(ref_con),
      .doubler_enable(dbl_en), .doubler_bypass_short(dbl_short), .booster_enable(bst_en),
      .booster_pulldown(bst_pd), .drive_regulator_enable(drv_en),
      .drive_heavy_load_mode(drv_hvy), .drive_range_select(drv_rng),
      .drive_contrast_level(drv_con), .boosted_voltage_settled(bst_ok),
      .display_drive_voltage_settled(drv_ok));
   dpc_analog_model u_analog (.doubler_enable(dbl_en), .doubler_bypass_short(dbl_short),
      .booster_enable(bst_en), .booster_pulldown(bst_pd), .drive_regulator_enable(drv_en),
      .short_live(short_live), .hv_live(hv_live));

   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic final_report;
      $display("comparisons=%0d mismatches=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // One APB transfer; an idle edge follows so the next setup never collides
   task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
         if (n > 50) begin
            failures++;
            final_report;
         end
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdchk(input string nm, input logic [19:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask : rdchk

   // Bounded wait on a settled flag; 0 picks the booster, 1 the drive regulator
   task automatic settle(input int which);
      int n;
      n = 0;
      while ((which ? drv_ok : bst_ok) !== 1'b1) begin
         @(posedge pclk);
         n++;
         if (n > 40) begin
            failures++;
            final_report;
         end
      end
   endtask : settle

   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      failures = 0;
      tests_run = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("ref_reset", A_REF, 32'h0000_0070);
      rdchk("drv_reset", A_DRV, 32'h0000_5000);
      apb(1'b1, A_REF, 32'hffff_ffff);
      rdchk("ref_rsvd", A_REF, 32'h0000_03f7);
      `CHK("short_gated", 1'b0, dbl_short)
      apb(1'b1, A_REF, 32'h0000_0200);
      `CHK("short_live", 1'b1, short_live)
      // Doubler runs while the regulator makes the lower level
      apb(1'b1, A_REF, 32'h0000_0105);
      `CHK("ref_ctl", 8'h85, {dbl_en, ref_con, ref_hvy, ref_sel, ref_en})
      apb(1'b1, A_REF, 32'h0000_00f1);
      `CHK("ref_con", 5'h1f, {ref_con, ref_en})
      // Every range code, with a contrast that differs each pass
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, A_DRV, {16'h0, 4'(15 - i), 2'(i), 10'h0});
         `CHK("range", {4'(15 - i), 2'(i)}, {drv_con, drv_rng})
         rdchk("drv_rd", A_DRV, {16'h0, 4'(15 - i), 2'(i), 10'h0});
      end
      apb(1'b1, A_DRV, 32'h0000_fefc);
      rdchk("drv_rsvd", A_DRV, 32'h0000_fe00);
      `CHK("drv_hv", 2'b10, {drv_hvy, drv_en})
      pstrb <= 4'h1;
      apb(1'b1, A_DRV, 32'h0000_0002);
      pstrb <= 4'hf;
      rdchk("lane0", A_DRV, 32'h0000_fe02);
      `CHK("pulldown", 2'b10, {bst_pd, hv_live})
      apb(1'b0, 20'h15804, 32'h0);
      `CHK("bad_err", 2'b10, {err, |rd})
      // Power-up order: booster, then drive regulator, each allowed to settle
      apb(1'b1, A_DRV, 32'h0000_0001);
      `CHK("bst_early", 1'b0, bst_ok)
      settle(0);
      apb(1'b1, A_DRV, 32'h0000_0101);
      settle(1);
      `CHK("hv_up", 1'b1, hv_live)
      // Status word: both settled flags up, no short applied
      rdchk("stat", 20'h15810, 32'h0000_0003);
      // Reset in mid-run brings back the reference default and clears drive and booster enables
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("ref_rst2", A_REF, 32'h0000_0070);
      `CHK("ctl_rst2", 2'b00, {drv_en, bst_en})
      final_report;
   end
endmodule : testbench
